// [rtl/ald_dark_level_readout.sv]
// Purpose: dark-level comparator and light sensor result registers
// Assumes: converter values and enables come from logic on sys_clk_i
// Notes:   register port is the byte layer behind the serial host interface
`timescale 1ns/10ps

// Overview of operation
// - photocurrent below dark trip code enters dark brightness mode
// - in dark mode, current above trip plus hysteresis returns to office or daylight mode
// - trip code is linear, 0.54 uA per step, 0 to 137.7 uA
// - hysteresis code uses the same 0.54 uA per step scale
// - sensor one low register shows result bits 7 to 0
// - sensor one high register shows result bits 12 to 8 as latched at the last low-byte read, in bits 4 to 0
// - sensor two low register shows result bits 7 to 0
// - sensor two high register shows result bits 12 to 8 as latched at the last low-byte read, in bits 4 to 0
// - enabled sensor result refreshes every 80 ms, disabled one holds
// - host writes to the four result registers change nothing
// - dark comparator wins over office comparator when choosing the mode
// - dark comparison on sensor two runs only while its enable is 1
module ald_dark_level_readout
	import ald_pkg::*;
#(
	parameter int unsigned REFRESH_CYCLES = REFRESH_CYC
) (
	// clock and reset
	input  wire logic                 sys_clk_i,
	input  wire logic                 rst_n_i,
	// register port from the serial interface
	input  wire logic [7:0]           reg_addr_i,
	input  wire logic [7:0]           reg_wdata_i,
	input  wire logic                 reg_wr_i,
	input  wire logic                 reg_rd_i,
	output logic      [7:0]           reg_rdata_o,
	// converter side
	input  wire logic [RESULT_W-1:0]  sensor_one_conv_i,
	input  wire logic [RESULT_W-1:0]  second_sensor_input_i,
	input  wire logic                 sensor_one_enable_i,
	input  wire logic                 sensor_two_enable_i,
	// comparator control and brightness mode
	input  wire logic                 sensor_two_dark_compare_enable_i,
	input  wire logic                 office_level_i,
	output ald_mode_t                 backlight_mode_o,
	output logic                      dark_active_o
);

	localparam int CNT_W = $clog2(REFRESH_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(REFRESH_CYCLES - 1);

	// read decode shared by the read mux and the snapshot logic
	function automatic logic is_low_addr(input logic [7:0] addr, input int idx);
		is_low_addr = (idx == 0) ? (addr == ADDR_S1_LOW) : (addr == ADDR_S2_LOW);
	endfunction : is_low_addr

	function automatic logic is_high_addr(input logic [7:0] addr, input int idx);
		is_high_addr = (idx == 0) ? (addr == ADDR_S1_HIGH) : (addr == ADDR_S2_HIGH);
	endfunction : is_high_addr

	logic [CNT_W-1:0]  cnt_ff,  nxt_cnt;
	logic              tick_ff, nxt_tick;
	logic [7:0]        dark_trip_code_ff,       nxt_dark_trip_code;
	logic [7:0]        dark_hysteresis_code_ff, nxt_dark_hysteresis_code;
	ald_result_t       result_ff [NUM_SENS];
	ald_result_t       nxt_result [NUM_SENS];
	logic [HIGH_W-1:0] hold_high_ff [NUM_SENS];
	logic [HIGH_W-1:0] nxt_hold_high [NUM_SENS];
	logic [7:0]        rdata_ff, nxt_rdata;
	ald_cmp_t          cmp_ff,  nxt_cmp;
	ald_mode_t         mode_ff, nxt_mode;
	logic              dark_ff, nxt_dark;
	logic [8:0]        exit_level;
	logic              below_trip;
	logic              above_exit;
	logic              conv_en [NUM_SENS];
	logic [RESULT_W-1:0] conv_val [NUM_SENS];

	assign conv_en[0]  = sensor_one_enable_i;
	assign conv_en[1]  = sensor_two_enable_i;
	assign conv_val[0] = sensor_one_conv_i;
	assign conv_val[1] = second_sensor_input_i;

	// free running refresh timebase, one tick per refresh period
	always_comb begin
		nxt_tick = 1'b0;
		nxt_cnt  = cnt_ff + CNT_W'(1);
		if (cnt_ff == CNT_LAST) begin
			nxt_cnt  = '0;
			nxt_tick = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_ff  <= '0;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			tick_ff <= nxt_tick;
		end
	end

	// host writable codes; result addresses decode to nothing here
	always_comb begin
		nxt_dark_trip_code       = dark_trip_code_ff;
		nxt_dark_hysteresis_code = dark_hysteresis_code_ff;
		if (reg_wr_i && reg_addr_i == ADDR_DARK_TRIP) begin
			nxt_dark_trip_code = reg_wdata_i;
		end
		if (reg_wr_i && reg_addr_i == ADDR_DARK_HYS) begin
			nxt_dark_hysteresis_code = reg_wdata_i;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dark_trip_code_ff       <= RST_DARK_TRIP;
			dark_hysteresis_code_ff <= RST_DARK_HYS;
		end else begin
			dark_trip_code_ff       <= nxt_dark_trip_code;
			dark_hysteresis_code_ff <= nxt_dark_hysteresis_code;
		end
	end

	// whole 13-bit word loads at once so the halves never split
	// a low-byte read snapshots the high part for a coherent pair
	always_comb begin
		for (int i = 0; i < NUM_SENS; i++) begin
			nxt_result[i]    = result_ff[i];
			nxt_hold_high[i] = hold_high_ff[i];
			if (tick_ff && conv_en[i]) begin
				nxt_result[i] = ald_result_t'(conv_val[i]);
			end
			if (reg_rd_i && is_low_addr(reg_addr_i, i)) begin
				nxt_hold_high[i] = result_ff[i].high;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < NUM_SENS; i++) begin
				result_ff[i]    <= ald_result_t'(RST_RESULT);
				hold_high_ff[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NUM_SENS; i++) begin
				result_ff[i]    <= nxt_result[i];
				hold_high_ff[i] <= nxt_hold_high[i];
			end
		end
	end

	// registered read data, one cycle after the read strobe
	always_comb begin
		nxt_rdata = rdata_ff;
		if (reg_rd_i) begin
			nxt_rdata = RD_UNMAPPED;
			if (reg_addr_i == ADDR_DARK_TRIP) begin
				nxt_rdata = dark_trip_code_ff;
			end
			if (reg_addr_i == ADDR_DARK_HYS) begin
				nxt_rdata = dark_hysteresis_code_ff;
			end
			for (int i = 0; i < NUM_SENS; i++) begin
				if (is_low_addr(reg_addr_i, i)) begin
					nxt_rdata = result_ff[i].low;
				end
				if (is_high_addr(reg_addr_i, i)) begin
					nxt_rdata = {3'h0, hold_high_ff[i]};
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_ff <= RD_UNMAPPED;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// codes share the 0.54 uA step with the conversion, so plain compare
	// nine-bit sum keeps trip plus hysteresis from wrapping
	assign exit_level = {1'b0, dark_trip_code_ff} + {1'b0, dark_hysteresis_code_ff};
	assign below_trip = second_sensor_input_i < {5'h00, dark_trip_code_ff};
	assign above_exit = second_sensor_input_i > {4'h0, exit_level};

	// dark comparator, evaluated on each fresh sensor two conversion
	always_comb begin
		nxt_cmp = cmp_ff;
		if (!sensor_two_dark_compare_enable_i) begin
			nxt_cmp = ALD_CMP_LIGHT;
		end else if (tick_ff && sensor_two_enable_i) begin
			unique case (cmp_ff)
				ALD_CMP_LIGHT: begin
					if (below_trip) begin
						nxt_cmp = ALD_CMP_DARK;
					end
				end
				ALD_CMP_DARK: begin
					if (above_exit) begin
						nxt_cmp = ALD_CMP_LIGHT;
					end
				end
			endcase
		end
	end

	// mode follows the comparator next cycle; dark overrides office
	always_comb begin
		nxt_dark = (cmp_ff == ALD_CMP_DARK);
		if (cmp_ff == ALD_CMP_DARK) begin
			nxt_mode = ALD_DARK;
		end else if (office_level_i) begin
			nxt_mode = ALD_OFFICE;
		end else begin
			nxt_mode = ALD_DAYLIGHT;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cmp_ff  <= ALD_CMP_LIGHT;
			mode_ff <= ALD_DAYLIGHT;
			dark_ff <= 1'b0;
		end else begin
			cmp_ff  <= nxt_cmp;
			mode_ff <= nxt_mode;
			dark_ff <= nxt_dark;
		end
	end

	assign reg_rdata_o      = rdata_ff;
	assign backlight_mode_o = mode_ff;
	assign dark_active_o    = dark_ff;

	// checks
	default clocking ald_cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence seq_fresh_two;
		tick_ff && sensor_two_enable_i && sensor_two_dark_compare_enable_i;
	endsequence

	// comparator state flips first, flag and mode follow one edge later
	sequence seq_dark_in_two;
		(cmp_ff == ALD_CMP_DARK) ##1 (dark_ff && backlight_mode_o == ALD_DARK);
	endsequence

	AST_DARK_ENTER: assert property (
		seq_fresh_two and (below_trip && cmp_ff == ALD_CMP_LIGHT) |=> seq_dark_in_two)
		else $error("dark mode not entered below trip code");

	AST_DARK_EXIT: assert property (
		seq_fresh_two and (above_exit && cmp_ff == ALD_CMP_DARK)
		|=> ##1 !dark_ff && backlight_mode_o != ALD_DARK)
		else $error("dark mode not left above trip plus hysteresis");

	AST_DARK_BAND: assert property (
		seq_fresh_two and (!above_exit && cmp_ff == ALD_CMP_DARK) |=> cmp_ff == ALD_CMP_DARK)
		else $error("dark mode left inside hysteresis band");

	AST_CMP_DISABLED: assert property (
		!sensor_two_dark_compare_enable_i [*2] |=> !dark_ff)
		else $error("dark comparator active while disabled");

	AST_DARK_PRIORITY: assert property (
		dark_ff && office_level_i |-> backlight_mode_o == ALD_DARK)
		else $error("office mode shown while dark comparator active");

	AST_REFRESH_LOAD: assert property (
		tick_ff && sensor_one_enable_i |=> result_ff[0] == ald_result_t'($past(sensor_one_conv_i)))
		else $error("enabled sensor result not refreshed on tick");

	AST_REFRESH_HOLD: assert property (
		!(tick_ff && sensor_two_enable_i) |=> $stable(result_ff[1]))
		else $error("sensor result changed without an enabled refresh");

	AST_RO_WRITE: assert property (
		reg_wr_i && reg_addr_i == ADDR_S1_LOW && !tick_ff |=> $stable(result_ff[0]))
		else $error("host write altered a result register");

	AST_LOW_READ: assert property (
		reg_rd_i && reg_addr_i == ADDR_S1_LOW |=> reg_rdata_o == $past(result_ff[0].low))
		else $error("low byte read does not show result bits 7 to 0");

	AST_HIGH_PAIR: assert property (
		reg_rd_i && reg_addr_i == ADDR_S2_LOW ##1 (reg_rd_i && reg_addr_i == ADDR_S2_HIGH)
		|=> reg_rdata_o == {3'h0, $past(result_ff[1].high, 2)})
		else $error("high byte does not pair with the low byte read");

	AST_RSV_ZERO: assert property (
		reg_rd_i && (reg_addr_i == ADDR_S1_HIGH || reg_addr_i == ADDR_S2_HIGH)
		|=> reg_rdata_o[7:5] == 3'h0)
		else $error("reserved high byte bits not zero");

	AST_OFFICE_MODE: assert property (
		cmp_ff == ALD_CMP_LIGHT && office_level_i |=> backlight_mode_o == ALD_OFFICE)
		else $error("office mode not shown outside dark mode");

	AST_S2_LOW_READ: assert property (
		reg_rd_i && reg_addr_i == ADDR_S2_LOW |=> reg_rdata_o == $past(result_ff[1].low))
		else $error("sensor two low byte read does not show bits 7 to 0");

endmodule : ald_dark_level_readout

// [rtl/ald_pkg.sv]
// Purpose: shared constants and types for the dark-level readout block
// Assumes: 20 MHz system clock, byte-wide register port from the serial front end
// Notes:   threshold, hysteresis and sensor result codes share one 0.54 uA step
package ald_pkg;

	// register map, byte addresses on the serial register port
	localparam logic [7:0] ADDR_DARK_TRIP = 8'h1F;
	localparam logic [7:0] ADDR_DARK_HYS  = 8'h20;
	localparam logic [7:0] ADDR_S1_LOW    = 8'h21;
	localparam logic [7:0] ADDR_S1_HIGH   = 8'h22;
	localparam logic [7:0] ADDR_S2_LOW    = 8'h23;
	localparam logic [7:0] ADDR_S2_HIGH   = 8'h24;

	// field layout of the results
	localparam int RESULT_W  = 13;
	localparam int LOW_W     = 8;
	localparam int HIGH_W    = 5;
	localparam int HIGH_LSB  = 8;
	localparam int NUM_SENS  = 2;

	// reset values
	localparam logic [7:0]          RST_DARK_TRIP = 8'h00;
	localparam logic [7:0]          RST_DARK_HYS  = 8'h00;
	localparam logic [RESULT_W-1:0] RST_RESULT    = 13'h0000;
	localparam logic [7:0]          RD_UNMAPPED   = 8'h00;

	// refresh timing
	localparam int unsigned CLK_HZ      = 20_000_000;
	localparam int unsigned REFRESH_MS  = 80;
	localparam int unsigned REFRESH_CYC = REFRESH_MS * (CLK_HZ / 1000);

	// one sensor result, high part above low part
	typedef struct packed {
		logic [HIGH_W-1:0] high;
		logic [LOW_W-1:0]  low;
	} ald_result_t;

	// backlight brightness mode seen by the rest of the driver
	typedef enum logic [1:0] {
		ALD_DAYLIGHT,
		ALD_OFFICE,
		ALD_DARK
	} ald_mode_t;

	// dark-level comparator state
	typedef enum logic {
		ALD_CMP_LIGHT,
		ALD_CMP_DARK
	} ald_cmp_t;

endpackage : ald_pkg

// [bench/ald_host_model.sv]
// Purpose: host side of the register port, byte strobes
// Assumes: one strobe pulse per access, one held across a low-high pair, launched after a rising edge
// Notes:   idle address and data show the inverse of the last value
`timescale 1ns/10ps
module ald_host_model
	import ald_pkg::*;
(
	// clock
	input  wire logic       sys_clk_i,
	// register port
	output logic      [7:0] reg_addr_o,
	output logic      [7:0] reg_wdata_o,
	output logic            reg_wr_o,
	output logic            reg_rd_o,
	input  wire logic [7:0] reg_rdata_i
);
	// idle values at time zero
	initial begin
		reg_addr_o  = 8'h00;
		reg_wdata_o = 8'h00;
		reg_wr_o    = 1'b0;
		reg_rd_o    = 1'b0;
	end
	// one write pulse, then lines scrambled so stale data is never seen
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		reg_wr_o    <= 1'b1;
		reg_addr_o  <= a;
		reg_wdata_o <= d;
		@(posedge sys_clk_i);
		reg_wr_o    <= 1'b0;
		reg_addr_o  <= ~a;
		reg_wdata_o <= ~d;
	endtask : wr_reg
	// read data is launched at the edge that takes the strobe, taken one edge later
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk_i);
		reg_rd_o   <= 1'b1;
		reg_addr_o <= a;
		@(posedge sys_clk_i);
		reg_rd_o   <= 1'b0;
		reg_addr_o <= ~a;
		@(posedge sys_clk_i);
		d = reg_rdata_i;
	endtask : rd_reg
	// back to back low then high read, strobe held up across both
	task automatic rd_pair(input logic [7:0] a, output logic [7:0] lo, output logic [7:0] hi);
		@(posedge sys_clk_i);
		reg_rd_o   <= 1'b1;
		reg_addr_o <= a;
		@(posedge sys_clk_i);
		reg_addr_o <= a + 8'h01;
		@(posedge sys_clk_i);
		reg_rd_o   <= 1'b0;
		reg_addr_o <= ~a;
		lo = reg_rdata_i;
		@(posedge sys_clk_i);
		hi = reg_rdata_i;
	endtask : rd_pair
endmodule : ald_host_model

// [bench/testbench.sv]
// Purpose: self-checking bench for the dark-level readout block
// Assumes: short refresh period so ticks come every few cycles
// Notes:   integer model of results and comparator, checked after each step
`timescale 1ns/10ps
module testbench;
	import ald_pkg::*;
	localparam int unsigned RCYC = 16;
	logic                sys_clk, rst_n, wr, rd, en1, en2, cmp_en, office, dark;
	logic [7:0]          addr, wdata, rdata;
	logic [RESULT_W-1:0] conv1, conv2;
	logic [31:0]         lfsr_st;
	ald_mode_t           mode;
	int                  num_errors, n_checks, res1, res2, m_trip, m_hys, m_dark;

	// clock and time-zero input values
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	initial begin
		{rst_n, en1, en2, cmp_en, office} = 5'h00;
		{conv1, conv2} = 26'h0;
		{num_errors, n_checks, res1, res2, m_trip, m_hys, m_dark} = '0;
		lfsr_st = 32'hD7B4B8D6;
	end

	ald_dark_level_readout #(.REFRESH_CYCLES(RCYC)) dut (
		.sys_clk_i(sys_clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .sensor_one_conv_i(conv1),
		.second_sensor_input_i(conv2), .sensor_one_enable_i(en1),
		.sensor_two_enable_i(en2), .sensor_two_dark_compare_enable_i(cmp_en),
		.office_level_i(office), .backlight_mode_o(mode), .dark_active_o(dark));
	ald_host_model host (
		.sys_clk_i(sys_clk), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr),
		.reg_rd_o(rd), .reg_rdata_i(rdata));

	// pseudo-random source, fixed start value
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	task automatic chk(input string nm, input logic [12:0] exp, input logic [12:0] got);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
		end
	endtask : chk

	task automatic rd_chk(input logic [7:0] a, input int e);
		logic [7:0] d;
		host.rd_reg(a, d);
		chk($sformatf("reg %0h", a), e[12:0], {5'h00, d});
	endtask : rd_chk

	// low and high byte read with no gap, so the pair must come from one word
	task automatic pair_chk(input logic [7:0] a, input int e);
		logic [7:0] lo, hi;
		host.rd_pair(a, lo, hi);
		chk($sformatf("pair %0h low", a), e[12:0] & 13'h00FF, {5'h00, lo});
		chk($sformatf("pair %0h high", a), e[12:0] >> 8, {5'h00, hi});
	endtask : pair_chk

	// apply inputs, let two ticks pass, then compare against the model
	task automatic step(input int c1, c2, e1, e2, ce, of);
		@(posedge sys_clk);
		conv1  <= c1[12:0];
		conv2  <= c2[12:0];
		{en1, en2, cmp_en, office} <= {e1[0], e2[0], ce[0], of[0]};
		repeat (2 * RCYC + 4) @(posedge sys_clk);
		if (e1 != 0) res1 = c1;
		if (e2 != 0) res2 = c2;
		if (ce == 0) m_dark = 0;
		else if (e2 != 0) m_dark = m_dark ? int'(c2 <= m_trip + m_hys) : int'(c2 < m_trip);
		#1;
		chk("dark", m_dark[12:0], {12'h000, dark});
		chk("mode", m_dark ? 13'h2 : (of ? 13'h1 : 13'h0), {11'h000, mode});
		rd_chk(ADDR_S1_LOW, res1 & 8'hFF);
		rd_chk(ADDR_S1_HIGH, res1 >> 8);
		rd_chk(ADDR_S2_LOW, res2 & 8'hFF);
		rd_chk(ADDR_S2_HIGH, res2 >> 8);
		pair_chk(ADDR_S2_LOW, res2);
	endtask : step

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : test_done

	// watchdog, far beyond the roughly 1200 cycles the tests need
	initial begin
		repeat (40000) @(posedge sys_clk);
		num_errors++;
		test_done();
	end

	// dark entry and exit boundaries: conv2, compare enable, office level
	int tbl [8][3] = '{'{'h40, 1, 1}, '{'h3F, 1, 1}, '{'h50, 1, 0}, '{'h51, 1, 0},
		'{'h3F, 1, 0}, '{'h3F, 0, 1}, '{'h10, 0, 0}, '{'h1FFF, 1, 1}};

	initial begin
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int a = 'h1F; a <= 'h25; a++) rd_chk(a[7:0], 0);
		$display("test reset_values done");
		for (int a = 'h21; a <= 'h24; a++) host.wr_reg(a[7:0], 8'hFF);
		host.wr_reg(ADDR_DARK_TRIP, 8'h40);
		host.wr_reg(ADDR_DARK_HYS, 8'h10);
		host.wr_reg(8'h25, 8'h5A);
		m_trip = 'h40;
		m_hys  = 'h10;
		for (int a = 'h21; a <= 'h25; a++) rd_chk(a[7:0], 0);
		rd_chk(ADDR_DARK_TRIP, 'h40);
		rd_chk(ADDR_DARK_HYS, 'h10);
		$display("test registers done");
		foreach (tbl[i]) step('h123, tbl[i][0], 0, 1, tbl[i][1], tbl[i][2]);
		$display("test dark_compare done");
		for (int i = 0; i < 10; i++) begin
			lfsr_st = lfsr_next(lfsr_st);
			step(lfsr_st[12:0], lfsr_st[25:13], lfsr_st[26], lfsr_st[27],
				lfsr_st[28], lfsr_st[29]);
		end
		$display("test random_refresh done");
		host.wr_reg(ADDR_DARK_TRIP, 8'hFF);
		host.wr_reg(ADDR_DARK_HYS, 8'hFF);
		m_trip = 'hFF;
		m_hys  = 'hFF;
		step(0, 'hFE, 1, 1, 1, 0);
		step(0, 'h1FE, 1, 1, 1, 0);
		step(0, 'h1FF, 1, 1, 1, 1);
		$display("test full_scale done");
		@(posedge sys_clk);
		{en1, en2, cmp_en, office} <= 4'h0;
		rst_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		#1;
		chk("dark", 13'h0000, {12'h000, dark});
		chk("mode", 13'h0000, {11'h000, mode});
		for (int a = 'h1F; a <= 'h24; a++) rd_chk(a[7:0], 0);
		$display("test mid_reset done");
		test_done();
	end
endmodule : testbench
